// ===== core/sacr_pkg.sv
package sacr_pkg;
    // Alarm codes, bit order {bit_three, bit_two, bit_one}; 1 = transistor on
    localparam logic [2:0] SACR_CODE_NONE = 3'h0;
    localparam logic [2:0] SACR_CODE_ABS = 3'h0;
    localparam logic [2:0] SACR_CODE_CONST = 3'h0;
    localparam logic [2:0] SACR_CODE_OVC = 3'h1;
    localparam logic [2:0] SACR_CODE_POS = 3'h3;
    // Bit positions in, and width of, the function select constant
    localparam int SACR_SENSOR_MODE_BIT = 1;
    localparam int SACR_ABS_ENC_BIT = 14;
    localparam int SACR_CONST_W = 16;
    // Sensor-on minimum high time before a toggle
    localparam real SACR_CLK_MHZ = 25.0;
    localparam int SACR_SEN_HOLD_MS = 1300;
    localparam int SACR_SEN_HOLD_CYC =
        int'(SACR_SEN_HOLD_MS * 1000.0 * SACR_CLK_MHZ);
    typedef enum logic [1:0] {
        SACR_CHK_IDLE,
        SACR_CHK_RUN,
        SACR_CHK_DONE
    } sacr_chk_t;
endpackage : sacr_pkg

// ===== core/sacr_sync.sv
`timescale 1ns/10ps
module sacr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // Second stage alone reads the first
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : sacr_sync

// ===== core/sacr_top.sv
`timescale 1ns/10ps
module sacr_top #(
    parameter int CONST_COUNT = 16,
    parameter int SEN_HOLD_CYC = sacr_pkg::SACR_SEN_HOLD_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Host pins
    input wire logic sensor_on_request,
    input wire logic alarm_reset_request,
    // Configuration
    input wire logic [sacr_pkg::SACR_CONST_W-1:0] function_select_constant,
    input wire logic position_control,
    input wire logic incremental_encoder_attached,
    // Detectors
    input wire logic encoder_malfunction,
    input wire logic overcurrent_detect,
    input wire logic module_over_temp,
    input wire logic position_error_overflow,
    input wire logic write_was_interrupted,
    // Constant store check port
    output logic [$clog2(CONST_COUNT)-1:0] const_index,
    input wire logic const_in_range,
    // Alarm outputs
    output logic alarm_code_bit_one,
    output logic alarm_code_bit_two,
    output logic alarm_code_bit_three,
    output logic alarm_output_on,
    output logic sen_hold_met
);
    import sacr_pkg::*;

    localparam int IW = $clog2(CONST_COUNT);
    localparam int CW = $clog2(SEN_HOLD_CYC + 1);

    logic [2:0] pins_sync;
    logic sen_s, rst_s, temp_s;
    logic sen_prev_reg;
    logic [CW-1:0] sen_cnt_reg;
    logic abs_reg, brk_reg, rng_reg, ovc_reg, pos_reg;
    logic sen_rise;
    sacr_chk_t chk_reg;
    logic [IW-1:0] idx_reg;
    logic [2:0] code_next;
    logic any_alarm;

    // Sensor-on goes through inverted so the cleared synchroniser
    // reads as its idle high; no false rising edge after reset
    sacr_sync #(.WIDTH(3)) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in({!sensor_on_request, alarm_reset_request,
            module_over_temp}),
        .sync_out(pins_sync)
    );
    assign sen_s = !pins_sync[2];
    assign rst_s = pins_sync[1];
    assign temp_s = pins_sync[0];
    assign sen_rise = sen_s && !sen_prev_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sen_prev_reg <= 1'b1;
        end else begin
            sen_prev_reg <= sen_s;
        end
    end

    // High-time counter; saturates so the host can see the hold is met
    always_ff @(posedge sys_clk) begin
        if (srst || !sen_s) begin
            sen_cnt_reg <= '0;
        end else if (sen_cnt_reg != CW'(SEN_HOLD_CYC)) begin
            sen_cnt_reg <= sen_cnt_reg + 1'b1;
        end
    end
    assign sen_hold_met = (sen_cnt_reg == CW'(SEN_HOLD_CYC));

    // Absolute data error; set wins over recovery
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            abs_reg <= 1'b0;
        end else if (encoder_malfunction ||
                (function_select_constant[SACR_ABS_ENC_BIT] &&
                 incremental_encoder_attached)) begin
            abs_reg <= 1'b1;
        end else if (sen_rise && !position_control &&
                !function_select_constant[SACR_SENSOR_MODE_BIT]) begin
            abs_reg <= 1'b0;
        end
    end

    // Power-up scan of the constant store
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chk_reg <= SACR_CHK_IDLE;
            idx_reg <= '0;
            rng_reg <= 1'b0;
            brk_reg <= 1'b0;
        end else begin
            case (chk_reg)
                SACR_CHK_IDLE: begin
                    brk_reg <= write_was_interrupted;
                    chk_reg <= SACR_CHK_RUN;
                end
                SACR_CHK_RUN: begin
                    if (!const_in_range) begin
                        rng_reg <= 1'b1;
                    end
                    if (idx_reg == IW'(CONST_COUNT - 1)) begin
                        chk_reg <= SACR_CHK_DONE;
                    end else begin
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                SACR_CHK_DONE: begin
                    chk_reg <= SACR_CHK_DONE;
                end
                default: begin
                    chk_reg <= SACR_CHK_IDLE;
                end
            endcase
        end
    end
    assign const_index = idx_reg;

    // Overcurrent stays latched while the module is hot
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ovc_reg <= 1'b0;
        end else if (overcurrent_detect) begin
            ovc_reg <= 1'b1;
        end else if (rst_s && !temp_s) begin
            ovc_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pos_reg <= 1'b0;
        end else if (position_error_overflow && position_control) begin
            pos_reg <= 1'b1;
        end else if (rst_s) begin
            pos_reg <= 1'b0;
        end
    end

    // Power-up faults take priority as the display would show them
    always_comb begin
        if (abs_reg) begin
            code_next = SACR_CODE_ABS;
        end else if (brk_reg || rng_reg) begin
            code_next = SACR_CODE_CONST;
        end else if (ovc_reg) begin
            code_next = SACR_CODE_OVC;
        end else if (pos_reg) begin
            code_next = SACR_CODE_POS;
        end else begin
            code_next = SACR_CODE_NONE;
        end
    end
    assign any_alarm = abs_reg | brk_reg | rng_reg | ovc_reg | pos_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alarm_code_bit_one <= 1'b0;
            alarm_code_bit_two <= 1'b0;
            alarm_code_bit_three <= 1'b0;
            alarm_output_on <= 1'b0;
        end else begin
            alarm_code_bit_one <= code_next[0];
            alarm_code_bit_two <= code_next[1];
            alarm_code_bit_three <= code_next[2];
            alarm_output_on <= !any_alarm;
        end
    end

    a_abs_holds: assert property (@(posedge sys_clk) disable iff (srst)
        abs_reg && !sen_rise |=> abs_reg)
        else $error("absolute error dropped without recovery");
    a_abs_mode_lock: assert property (@(posedge sys_clk) disable iff (srst)
        abs_reg && (position_control ||
        function_select_constant[SACR_SENSOR_MODE_BIT]) |=> abs_reg)
        else $error("absolute error cleared in power-cycle mode");
    a_abs_recover: assert property (@(posedge sys_clk) disable iff (srst)
        abs_reg && sen_rise && !position_control && !encoder_malfunction &&
        !function_select_constant[SACR_SENSOR_MODE_BIT] &&
        !function_select_constant[SACR_ABS_ENC_BIT] |=> !abs_reg)
        else $error("sensor-on toggle did not recover");
    a_enc_mismatch: assert property (@(posedge sys_clk) disable iff (srst)
        function_select_constant[SACR_ABS_ENC_BIT] &&
        incremental_encoder_attached |=> abs_reg)
        else $error("encoder mismatch not flagged");
    a_ovc_hot_hold: assert property (@(posedge sys_clk) disable iff (srst)
        ovc_reg && temp_s |=> ovc_reg)
        else $error("overcurrent reset while hot");
    a_brk_flag: assert property (@(posedge sys_clk) disable iff (srst)
        chk_reg == SACR_CHK_IDLE && write_was_interrupted
        |=> brk_reg [*2])
        else $error("breakdown not raised");
    a_range_flag: assert property (@(posedge sys_clk) disable iff (srst)
        chk_reg == SACR_CHK_RUN && !const_in_range |=> rng_reg)
        else $error("range error not raised");
    a_ovc_code: assert property (@(posedge sys_clk) disable iff (srst)
        ovc_reg && !abs_reg && !brk_reg && !rng_reg |=>
        alarm_code_bit_one && !alarm_code_bit_two &&
        !alarm_code_bit_three && !alarm_output_on)
        else $error("overcurrent code wrong");
    a_pos_code: assert property (@(posedge sys_clk) disable iff (srst)
        pos_reg && !ovc_reg && !abs_reg && !brk_reg && !rng_reg |=>
        alarm_code_bit_one && alarm_code_bit_two &&
        !alarm_code_bit_three)
        else $error("position code wrong");
endmodule : sacr_top

// ===== verif/sacr_host.sv
`timescale 1ns/10ps
module sacr_host #(
    parameter int HOLD = 20
) (
    // Clock
    input wire logic sys_clk,
    // Toggle command
    input wire logic toggle_go,
    // Host pin
    output logic sensor_on_request
);
    int high_cnt = 0;
    initial sensor_on_request = 1'b1;
    always @(posedge sys_clk) begin
        high_cnt <= sensor_on_request ? high_cnt + 1 : 0;
    end
    // Never drop early, even when asked at once
    always @(posedge sys_clk) begin
        if (toggle_go) begin
            while (high_cnt <= HOLD) @(posedge sys_clk);
            sensor_on_request <= 1'b0;
            repeat (4) @(posedge sys_clk);
            sensor_on_request <= 1'b1;
        end
    end
endmodule : sacr_host

// ===== verif/servo_alarm_code_reporter_bench.sv
`timescale 1ns/10ps
module servo_alarm_code_reporter_bench;
    import sacr_pkg::*;
    localparam int HOLD = 20;
    logic sys_clk = 0, srst = 1, alarm_reset_request = 0, toggle_go = 0;
    logic [SACR_CONST_W-1:0] fsc = '0;
    logic position_control = 0, inc = 0, encoder_malfunction = 0;
    logic overcurrent_detect = 0, module_over_temp = 0;
    logic position_error_overflow = 0, write_was_interrupted = 0;
    logic sensor_on_request, const_in_range, sen_hold_met;
    logic [3:0] const_index;
    logic alarm_code_bit_one, alarm_code_bit_two, alarm_code_bit_three;
    logic alarm_output_on;
    logic [31:0] seed = 32'h0000_2673;
    int err_count = 0, tests_run = 0, cyc = 0, bad = 16;
    int m_abs = 0, m_cst = 0, m_ovc = 0, m_pos = 0;
    always #20 sys_clk = ~sys_clk;
    assign const_in_range = (int'(const_index) != bad);
    sacr_top #(.CONST_COUNT(16), .SEN_HOLD_CYC(HOLD)) dut (
        .sys_clk(sys_clk), .srst(srst),
        .sensor_on_request(sensor_on_request),
        .alarm_reset_request(alarm_reset_request),
        .function_select_constant(fsc),
        .position_control(position_control),
        .incremental_encoder_attached(inc),
        .encoder_malfunction(encoder_malfunction),
        .overcurrent_detect(overcurrent_detect),
        .module_over_temp(module_over_temp),
        .position_error_overflow(position_error_overflow),
        .write_was_interrupted(write_was_interrupted),
        .const_index(const_index), .const_in_range(const_in_range),
        .alarm_code_bit_one(alarm_code_bit_one),
        .alarm_code_bit_two(alarm_code_bit_two),
        .alarm_code_bit_three(alarm_code_bit_three),
        .alarm_output_on(alarm_output_on), .sen_hold_met(sen_hold_met));
    sacr_host #(.HOLD(HOLD)) host (.sys_clk(sys_clk),
        .toggle_go(toggle_go), .sensor_on_request(sensor_on_request));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    // Priority abs, constants, overcurrent, position
    task automatic chk();
        logic [3:0] e, g;
        e = m_abs || m_cst ? 4'h0 : m_ovc ? 4'h1 : m_pos ? 4'h3 : 4'h8;
        @(negedge sys_clk);
        g = {alarm_output_on, alarm_code_bit_three, alarm_code_bit_two,
            alarm_code_bit_one};
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] alarm outputs exp %h got %h", e, g);
        end
    endtask : chk
    task automatic chk_bit(input logic e);
        @(negedge sys_clk);
        tests_run++;
        if (sen_hold_met !== e) begin
            err_count++;
            $display("[ERR] sen_hold_met exp %b got %b", e, sen_hold_met);
        end
    endtask : chk_bit
    task automatic pwr(input logic brk, input int b);
        @(posedge sys_clk);
        srst <= 1;
        write_was_interrupted <= brk;
        bad = b;
        wt(2);
        srst <= 0;
        m_abs = fsc[14] && inc;
        m_cst = brk || b < 16;
        m_ovc = 0;
        m_pos = 0;
        wt(24);
        chk();
    endtask : pwr
    task automatic clr();
        @(posedge sys_clk);
        alarm_reset_request <= 1;
        wt(6);
        alarm_reset_request <= 0;
        wt(6);
        m_ovc = m_ovc && module_over_temp;
        m_pos = 0;
    endtask : clr
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        seed = lfsr(seed);
        pwr(1, 16);
        pwr(0, 0);
        pwr(0, 15);
        pwr(0, int'(seed[3:0]));
        pwr(0, 16);
        @(posedge sys_clk);
        overcurrent_detect <= 1;
        module_over_temp <= 1;
        position_control <= 1;
        position_error_overflow <= 1;
        m_ovc = 1;
        m_pos = 1;
        wt(1);
        overcurrent_detect <= 0;
        position_error_overflow <= 0;
        wt(4);
        chk();
        clr();
        chk();
        @(posedge sys_clk);
        module_over_temp <= 0;
        position_error_overflow <= 1;
        m_pos = 1;
        wt(1);
        position_error_overflow <= 0;
        wt(4);
        chk();
        clr();
        chk();
        @(posedge sys_clk);
        position_error_overflow <= 1;
        m_pos = 1;
        wt(1);
        position_error_overflow <= 0;
        wt(4);
        chk();
        @(posedge sys_clk);
        fsc[14] <= 1;
        inc <= 1;
        m_abs = 1;
        wt(5);
        chk();
        clr();
        chk();
        @(posedge sys_clk);
        fsc[14] <= 0;
        pwr(0, 16);
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            seed = lfsr(seed);
            fsc <= {seed[15], 1'b0, seed[13:2], k == 1, seed[0]};
            position_control <= (k == 2);
            encoder_malfunction <= 1;
            m_abs = 1;
            wt(1);
            encoder_malfunction <= 0;
            wt(4);
            chk();
            @(posedge sys_clk);
            toggle_go <= 1;
            wt(1);
            toggle_go <= 0;
            wt(10);
            chk_bit(0);
            wt(HOLD + 10);
            chk_bit(1);
            if (k == 0) m_abs = 0;
            chk();
            pwr(0, 16);
        end
        print_verdict();
    end
endmodule : servo_alarm_code_reporter_bench
